// file: verilog/sbph_port.v
// Two-way strobed byte port with handshake and third-port status
`timescale 1ns/10ps
`include "sbph_defines.vh"
module sbph_port
(
  input  wire       CLK_I,                 // System clock, 100 MHz
  input  wire       RST_N_I,               // Async reset, active low
  input  wire       CS_N_I,                // Chip select, active low
  input  wire       RD_N_I,                // Host read strobe
  input  wire       WR_N_I,                // Host write strobe
  input  wire [1:0] ADR_I,                 // Register select
  input  wire [7:0] HOST_D_I,              // Host data in
  output reg  [7:0] HOST_D_O,              // Host data out
  output reg        HOST_D_OE_O,           // Host bus driven
  input  wire [7:0] PEER_D_I,              // First port pins in
  output reg  [7:0] PEER_D_O,              // First port pins out
  output reg        PEER_D_OE_O,           // First port driven
  input  wire       PEER_STROBE_N_I,       // Peer strobe, active low
  input  wire       PEER_ACK_N_I,          // Peer acknowledge, low
  output reg        OUT_LATCH_FULL_N_O,    // Output full, active low
  output reg        IN_LATCH_FULL_O,       // Input latch full
  output reg        IRQ_OUT_O,             // Interrupt request
  input  wire [2:0] THIRD_LOW_I,           // Third port bits 2..0 in
  input  wire       GROUP_B_MODE_I,        // Group B strobed: 1
  input  wire       GROUP_B_DIR_IN_I,      // Group B direction input
  input  wire       GROUP_B_FULL_I,        // Group B full flag
  input  wire       GROUP_B_IRQ_I,         // Group B interrupt
  output reg  [2:0] THIRD_LOW_O,           // Third port bits 2..0 out
  output reg        THIRD_LOW_OE_O,        // Low bits driven
  input  wire       LOW_DIR_IN_I,          // Low bits are inputs
  output reg        GROUP_B_IRQ_EN_O       // Group B enable flop
);
  // Synchronised inputs
  wire stb_s;                              // Strobe, synced
  wire ack_s;                              // Acknowledge, synced
  wire rd_s;                               // Read strobe, synced
  wire wr_s;                               // Write strobe, synced
  reg  stb_d_ff;                           // Previous strobe
  reg  ack_d_ff;                           // Previous ack
  reg  rd_d_ff;                            // Previous read
  reg  wr_d_ff;                            // Previous write
  reg  cs_ff;                              // Chip select, registered
  reg  [1:0] adr_ff;                       // Address, registered
  reg  [7:0] hd_ff;                        // Host data, registered
  wire stb_fall;                           // Strobe edges
  wire stb_rise;
  wire ack_fall;                           // Ack edges
  wire ack_rise;
  wire rd_fall;                            // Read edges
  wire rd_rise;
  wire wr_rise;                            // Write edges
  wire wr_fall;
  // Handshake state
  reg  [7:0] in_latch_ff;                  // Captured peer byte
  reg  [7:0] out_buf_ff;                   // Byte to peer
  reg        obf_n_ff;                     // Output full, low active
  reg        ibf_ff;                       // Input full
  reg        tx_irq_enable_ff;             // Transmit enable
  reg        rx_irq_enable_ff;             // Receive enable
  reg        tx_irq_ff;                    // Transmit cause
  reg        rx_irq_ff;                    // Receive cause
  reg  [2:0] low_out_ff;                   // Lower unused outputs
  reg        stb_seen_ff;                  // Strobe low seen, rise due
  reg        ack_seen_ff;                  // Ack low seen, rise due
  wire [7:0] status;                       // Third-port read word
  wire [2:0] gb_status;                    // Group B section
  wire       host_rd_a;                    // Read of first port
  wire       host_wr_a;                    // Write of first port
  wire       host_wr_c;                    // Write of third port
  wire       host_wr_ctl;                  // Control write
  wire [2:0] bit_sel;                      // Set/reset bit index
  wire [7:0] low_wr_word;                  // Plain third-port write word
  // Fifo between host writes and output buffer
  wire       fifo_in_ready;                // Space for host byte
  wire [7:0] fifo_q;                       // Head byte
  wire       fifo_q_valid;                 // Head valid
  wire       fifo_take;                    // Move head to buffer

  // Synchronisers for asynchronous strobes
  sbph_sync #(.RST_VAL(1'b1)) u_stb
  (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (PEER_STROBE_N_I),
    .q_o     (stb_s)
  );
  sbph_sync #(.RST_VAL(1'b1)) u_ack
  (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (PEER_ACK_N_I),
    .q_o     (ack_s)
  );
  sbph_sync #(.RST_VAL(1'b1)) u_rd
  (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (RD_N_I),
    .q_o     (rd_s)
  );
  sbph_sync #(.RST_VAL(1'b1)) u_wr
  (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (WR_N_I),
    .q_o     (wr_s)
  );

  // Edges from synchronised values
  // History resets idle high, so no false edge follows reset
  assign stb_fall = stb_d_ff & ~stb_s;
  assign stb_rise = ~stb_d_ff & stb_s;
  assign ack_fall = ack_d_ff & ~ack_s;
  assign ack_rise = ~ack_d_ff & ack_s;
  assign rd_fall  = rd_d_ff & ~rd_s;
  assign rd_rise  = ~rd_d_ff & rd_s;
  assign wr_fall  = wr_d_ff & ~wr_s;
  assign wr_rise  = ~wr_d_ff & wr_s;

  // Host decode; address and data held while strobe low
  assign host_rd_a   = rd_rise & cs_ff & (adr_ff == `SBPH_ADR_FIRST);
  assign host_wr_a   = wr_rise & cs_ff & (adr_ff == `SBPH_ADR_FIRST);
  assign host_wr_c   = wr_rise & cs_ff & (adr_ff == `SBPH_ADR_THIRD);
  assign host_wr_ctl = wr_rise & cs_ff & (adr_ff == `SBPH_ADR_CTRL)
                       & ~hd_ff[`SBPH_CW_MODE_BIT];
  assign bit_sel     = hd_ff[`SBPH_CW_SEL_MSB:`SBPH_CW_SEL_LSB];
  // Only the three lower bits take a plain write
  assign low_wr_word = hd_ff & `SBPH_LOW_WR_MASK;

  // Buffer accepts a new byte once the previous one was taken
  // and its acknowledge has ended; reloading while acknowledge is
  // still low would swap the byte on the pins under the peer and
  // hide the transmit interrupt at the acknowledge rise
  assign fifo_take = fifo_q_valid & obf_n_ff & ack_s & ~ack_seen_ff;

  sbph_fifo
  #(
    .W  (`SBPH_FIFO_W),
    .D  (`SBPH_FIFO_D),
    .AW (`SBPH_FIFO_AW)
  )
  u_fifo
  (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .in_data_i   (hd_ff),
    .in_valid_i  (host_wr_a),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_q),
    .out_valid_o (fifo_q_valid),
    .out_ready_i (fifo_take)
  );

  // Group B section of status word
  assign gb_status = GROUP_B_MODE_I ?
                     {GROUP_B_IRQ_EN_O, GROUP_B_FULL_I, GROUP_B_IRQ_I} :
                     (LOW_DIR_IN_I ? THIRD_LOW_I : low_out_ff);

  // Two-way status word
  assign status = {obf_n_ff, tx_irq_enable_ff, ibf_ff,
                   rx_irq_enable_ff, IRQ_OUT_O, gb_status};

  // Pipeline registers and edge history
  // Host holds select, address and data until synced strobe rises
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      stb_d_ff <= 1'b1;
      ack_d_ff <= 1'b1;
      rd_d_ff  <= 1'b1;
      wr_d_ff  <= 1'b1;
      cs_ff    <= 1'b0;
      adr_ff   <= 2'h0;
      hd_ff    <= `SBPH_RST_BYTE;
    end
    else
    begin
      stb_d_ff <= stb_s;
      ack_d_ff <= ack_s;
      rd_d_ff  <= rd_s;
      wr_d_ff  <= wr_s;
      // Sample address/data only while a strobe is low
      if (~rd_s | ~wr_s)
      begin
        cs_ff  <= ~CS_N_I;
        adr_ff <= ADR_I;
        hd_ff  <= HOST_D_I;
      end
    end
  end

  // Handshake flags, latches and enables
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      in_latch_ff      <= `SBPH_RST_BYTE;
      out_buf_ff       <= `SBPH_RST_BYTE;
      obf_n_ff         <= 1'b1;
      ibf_ff           <= 1'b0;
      tx_irq_enable_ff <= 1'b0;
      rx_irq_enable_ff <= 1'b0;
      tx_irq_ff        <= 1'b0;
      rx_irq_ff        <= 1'b0;
      low_out_ff       <= 3'h0;
      stb_seen_ff      <= 1'b0;
      ack_seen_ff      <= 1'b0;
      GROUP_B_IRQ_EN_O <= 1'b0;
    end
    else
    begin
      // Capture peer byte on strobe fall
      if (stb_fall)
        in_latch_ff <= PEER_D_I;
      // Input-full: set wins over read-rise clear
      if (stb_fall)
        ibf_ff <= 1'b1;
      else if (host_rd_a)
        ibf_ff <= 1'b0;
      // Strobe pending its rising edge
      if (stb_fall)
        stb_seen_ff <= 1'b1;
      else if (stb_rise)
        stb_seen_ff <= 1'b0;
      // Receive interrupt; set wins over clear
      // At read fall the registered select still holds the last
      // cycle, so the clear looks at the live select and address
      if (stb_rise & stb_seen_ff & ibf_ff & rx_irq_enable_ff)
        rx_irq_ff <= 1'b1;
      else if (rd_fall & ~CS_N_I & (ADR_I == `SBPH_ADR_FIRST))
        rx_irq_ff <= 1'b0;
      // Output buffer loaded from fifo, output-full low
      if (fifo_take)
      begin
        out_buf_ff <= fifo_q;
        obf_n_ff   <= 1'b0;
      end
      else if (ack_fall)
        obf_n_ff <= 1'b1;
      if (ack_fall)
        ack_seen_ff <= 1'b1;
      else if (ack_rise)
        ack_seen_ff <= 1'b0;
      // Transmit interrupt; set wins over clear
      if (ack_rise & ack_seen_ff & obf_n_ff & tx_irq_enable_ff)
        tx_irq_ff <= 1'b1;
      else if (wr_fall & ~CS_N_I & (ADR_I == `SBPH_ADR_FIRST))
        tx_irq_ff <= 1'b0;
      // Bit set/reset command
      // Selects 7, 5 and 3 are handshake lines and are ignored
      if (host_wr_ctl)
      begin
        case (bit_sel)
          3'h6: tx_irq_enable_ff <= hd_ff[`SBPH_CW_SET_BIT];
          3'h4: rx_irq_enable_ff <= hd_ff[`SBPH_CW_SET_BIT];
          3'h2: GROUP_B_IRQ_EN_O <= hd_ff[`SBPH_CW_SET_BIT];
          3'h1: low_out_ff[1]    <= hd_ff[`SBPH_CW_SET_BIT];
          3'h0: low_out_ff[0]    <= hd_ff[`SBPH_CW_SET_BIT];
          default: low_out_ff    <= low_out_ff;
        endcase
      end
      else if (host_wr_c)
        // Plain write reaches only the three lower bits
        low_out_ff <= low_wr_word[2:0];
    end
  end

  // Registered pin and bus outputs
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      HOST_D_O           <= `SBPH_RST_BYTE;
      HOST_D_OE_O        <= 1'b0;
      PEER_D_O           <= `SBPH_RST_BYTE;
      PEER_D_OE_O        <= 1'b0;
      OUT_LATCH_FULL_N_O <= 1'b1;
      IN_LATCH_FULL_O    <= 1'b0;
      IRQ_OUT_O          <= 1'b0;
      THIRD_LOW_O        <= 3'h0;
      THIRD_LOW_OE_O     <= 1'b0;
    end
    else
    begin
      PEER_D_O           <= out_buf_ff;
      // First port driven only while synced acknowledge low
      PEER_D_OE_O        <= ~ack_s;
      OUT_LATCH_FULL_N_O <= obf_n_ff;
      IN_LATCH_FULL_O    <= ibf_ff;
      IRQ_OUT_O          <= tx_irq_ff | rx_irq_ff;
      THIRD_LOW_O        <= low_out_ff;
      // Lower bits driven only as plain outputs
      THIRD_LOW_OE_O     <= ~LOW_DIR_IN_I & ~GROUP_B_MODE_I;
      // Host bus driven for any readable address
      HOST_D_OE_O        <= ~rd_s & ~CS_N_I & ~ADR_I[1]
                            | ~rd_s & ~CS_N_I & ~ADR_I[0];
      // Read mux
      case (ADR_I)
        `SBPH_ADR_FIRST: HOST_D_O <= in_latch_ff;
        `SBPH_ADR_THIRD: HOST_D_O <= status;
        default:         HOST_D_O <= `SBPH_RST_BYTE;
      endcase
    end
  end
endmodule // sbph_port

// file: common/sbph_defines.vh
// Constants for the strobed bidirectional byte port with handshake
`ifndef SBPH_DEFINES_VH
`define SBPH_DEFINES_VH
// Host address decode
`define SBPH_ADR_FIRST    2'b00
`define SBPH_ADR_SECOND   2'b01
`define SBPH_ADR_THIRD    2'b10
`define SBPH_ADR_CTRL     2'b11
// Control word fields
`define SBPH_CW_MODE_BIT  7
`define SBPH_CW_SET_BIT   0
`define SBPH_CW_SEL_LSB   1
`define SBPH_CW_SEL_MSB   3
// Third port bit positions in two-way mode
`define SBPH_POS_OBF      7
`define SBPH_POS_TXE      6
`define SBPH_POS_IBF      5
`define SBPH_POS_RXE      4
`define SBPH_POS_IRQ      3
// Group B status layouts (selected by group_b_mode_i)
`define SBPH_GB_POS_EN    2
`define SBPH_GB_POS_FULL  1
`define SBPH_GB_POS_IRQ   0
// Writable lower bits by plain write
`define SBPH_LOW_WR_MASK  8'h07
// Reset values
`define SBPH_RST_BYTE     8'h00
// Fifo
`define SBPH_FIFO_W       8
`define SBPH_FIFO_D       4
`define SBPH_FIFO_AW      2
`endif

// file: verilog/sbph_sync.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module sbph_sync
#(
  parameter RST_VAL = 1'b1                 // Idle level after reset
)
(
  input  wire clk_i,                       // System clock
  input  wire rst_n_i,                     // Async reset, active low
  input  wire d_i,                         // Asynchronous input
  output reg  q_o                          // Synchronised output
);
  reg meta_ff;                             // First stage, read by q only

  // Two stages
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= RST_VAL;
      q_o     <= RST_VAL;
    end
    else
    begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule // sbph_sync

// file: verilog/sbph_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sbph_fifo
#(
  parameter W  = 8,                        // Word width
  parameter D  = 4,                        // Depth in words
  parameter AW = 2                         // Pointer width
)
(
  input  wire          clk_i,              // System clock
  input  wire          rst_n_i,            // Async reset, active low
  input  wire [W-1:0]  in_data_i,          // Write word
  input  wire          in_valid_i,         // Write request
  output wire          in_ready_o,         // Not full
  output reg  [W-1:0]  out_data_o,         // Head word, registered
  output reg           out_valid_o,        // Head valid
  input  wire          out_ready_i         // Drain accepts head
);
  reg [W-1:0]  mem_ff [0:D-1];             // Storage
  reg [AW-1:0] wp_ff;                      // Write pointer
  reg [AW-1:0] rp_ff;                      // Read pointer
  reg [AW:0]   cnt_ff;                     // Words stored in array
  wire         push;                       // Word enters
  wire         pop;                        // Word moves to head
  wire         load;                       // Head register may load

  assign in_ready_o = (cnt_ff != D[AW:0]);
  assign push = in_valid_i & in_ready_o;
  assign load = ~out_valid_o | out_ready_i;
  assign pop  = load & (cnt_ff != {(AW+1){1'b0}});

  // Storage array, no reset needed
  always @(posedge clk_i)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data_i;
  end

  // Pointers, count, registered head
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_ff       <= {AW{1'b0}};
      rp_ff       <= {AW{1'b0}};
      cnt_ff      <= {(AW+1){1'b0}};
      out_data_o  <= {W{1'b0}};
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        rp_ff      <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
        out_data_o <= mem_ff[rp_ff];
      end
      if (load)
        out_valid_o <= pop;
      if (push & ~pop)
        cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // sbph_fifo

// file: test/sbph_port_props.sv
// Checker for the two-way strobed byte port
`timescale 1ns/10ps
module sbph_port_props
(
  input wire CLK_I,                // System clock
  input wire RST_N_I,              // Async reset, active low
  input wire RD_N_I,               // Host read strobe
  input wire WR_N_I,               // Host write strobe
  input wire PEER_STROBE_N_I,      // Peer strobe
  input wire PEER_ACK_N_I,         // Peer acknowledge
  input wire PEER_D_OE_O,          // First port driven
  input wire HOST_D_OE_O,          // Host bus driven
  input wire OUT_LATCH_FULL_N_O,   // Output full, active low
  input wire IN_LATCH_FULL_O,      // Input full
  input wire IRQ_OUT_O             // Interrupt request
);
  reg [3:0] rd_ago_ff;             // Cycles since read strobe low
  reg [3:0] wr_ago_ff;             // Cycles since write strobe low
  reg [3:0] ack_ago_ff;            // Cycles since acknowledge low
  reg [3:0] stb_ago_ff;            // Cycles since peer strobe low
  // Saturating age of a strobe
  function [3:0] nxt_age(input act, input [3:0] c);
    nxt_age = act ? 4'h0 : (c == 4'hf) ? c : c + 4'h1;
  endfunction
  // Age counters, idle after reset
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rd_ago_ff  <= 4'hf;
      wr_ago_ff  <= 4'hf;
      ack_ago_ff <= 4'hf;
      stb_ago_ff <= 4'hf;
    end
    else
    begin
      rd_ago_ff  <= nxt_age(!RD_N_I, rd_ago_ff);
      wr_ago_ff  <= nxt_age(!WR_N_I, wr_ago_ff);
      ack_ago_ff <= nxt_age(!PEER_ACK_N_I, ack_ago_ff);
      stb_ago_ff <= nxt_age(!PEER_STROBE_N_I, stb_ago_ff);
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_drive_on_ack:
    assert property (!PEER_ACK_N_I [*5] |-> PEER_D_OE_O)
    else $error("First port not driven under acknowledge");
  a_float_off_ack:
    assert property (PEER_ACK_N_I [*5] |-> !PEER_D_OE_O)
    else $error("First port driven without acknowledge");
  a_ibf_on_strobe:
    assert property ($fell(PEER_STROBE_N_I) |-> ##[1:6] IN_LATCH_FULL_O)
    else $error("Input full missing after strobe");
  a_ibf_rise_cause:
    assert property ($rose(IN_LATCH_FULL_O) |-> stb_ago_ff < 4'h8)
    else $error("Input full rose without strobe");
  a_ibf_fall_cause:
    assert property ($fell(IN_LATCH_FULL_O) |-> rd_ago_ff < 4'h8)
    else $error("Input full fell without read");
  a_obf_rise_cause:
    assert property ($rose(OUT_LATCH_FULL_N_O) |-> ack_ago_ff < 4'h8)
    else $error("Output full ended without acknowledge");
  a_obf_held_low:
    assert property ((!OUT_LATCH_FULL_N_O && PEER_ACK_N_I) [*8]
                     |=> !OUT_LATCH_FULL_N_O)
    else $error("Output full dropped without acknowledge");
  a_irq_fall_cause:
    assert property ($fell(IRQ_OUT_O) |->
                     rd_ago_ff < 4'h8 || wr_ago_ff < 4'h8)
    else $error("Interrupt fell without host strobe");
  a_reset_state_ok:
    assert property ($rose(RST_N_I) |-> OUT_LATCH_FULL_N_O &&
                     !IN_LATCH_FULL_O && !IRQ_OUT_O)
    else $error("Flags wrong after reset");
  a_host_oe_read:
    assert property (HOST_D_OE_O |-> rd_ago_ff < 4'h6)
    else $error("Host bus driven outside a read");
endmodule // sbph_port_props
bind sbph_port sbph_port_props u_props
(
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I),
  .PEER_STROBE_N_I(PEER_STROBE_N_I), .PEER_ACK_N_I(PEER_ACK_N_I),
  .PEER_D_OE_O(PEER_D_OE_O), .HOST_D_OE_O(HOST_D_OE_O),
  .OUT_LATCH_FULL_N_O(OUT_LATCH_FULL_N_O),
  .IN_LATCH_FULL_O(IN_LATCH_FULL_O), .IRQ_OUT_O(IRQ_OUT_O)
);

// file: test/sbph_peer_model.sv
// Peripheral model: strobes bytes in, acknowledges bytes out
`timescale 1ns/10ps
module sbph_peer_model
(
  input  wire       clk_i,              // System clock
  input  wire [7:0] pins_i,             // Resolved first port pins
  input  wire       obf_n_i,            // Byte waiting, active low
  output reg  [7:0] pins_o = 8'ha5,     // Drive toward the port
  output reg        strobe_n_o = 1'b1,  // Strobe, active low
  output reg        ack_n_o = 1'b1      // Acknowledge, active low
);
  reg       stall = 1'b1;               // Hold off acknowledge
  integer   gap = 0;                    // Extra wait before acknowledge
  reg [7:0] got_q[$];                   // Bytes taken from the port
  // Present a byte, strobe it, then let it go
  task send(input [7:0] b);
  begin
    @(posedge clk_i);
    pins_o <= b;
    repeat (2) @(posedge clk_i);
    strobe_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    strobe_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    pins_o <= ~b;                       // Released: show the inverse
    repeat (8) @(posedge clk_i);
  end
  endtask
  // Acknowledge each waiting byte, promptly or late
  always
  begin
    @(posedge clk_i);
    if (!obf_n_i && !stall)
    begin
      repeat (gap) @(posedge clk_i);
      ack_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      got_q.push_back(pins_i);
      ack_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  end
endmodule // sbph_peer_model

// file: test/testbench.sv
// Self-checking bench for the two-way strobed byte port
`timescale 1ns/10ps
module testbench;
  reg        clk = 1'b0;        // System clock
  reg        rst_n = 1'b0;      // Reset, active low
  reg        cs_n = 1'b1;       // Chip select
  reg        rd_n = 1'b1;       // Read strobe
  reg        wr_n = 1'b1;       // Write strobe
  reg  [1:0] adr = 2'b00;       // Register select
  reg  [7:0] hd = 8'h00;        // Host write data
  reg  [2:0] low_in = 3'b000;   // Third port low pins
  reg        gb_mode = 1'b0;    // Group B strobed
  reg        gb_full = 1'b0;    // Group B full
  reg        gb_irq = 1'b0;     // Group B interrupt
  reg        low_dir = 1'b1;    // Low bits are inputs
  wire [7:0] host_q, peer_q, peer_drv, pins;
  wire       host_oe, peer_oe, stb_n, ack_n, obf_n, in_latch_full, irq;
  wire       low_oe, gb_en;
  wire [2:0] low_q;
  reg [31:0] seed = 32'h166e;   // Random state
  reg  [7:0] q;                 // Last host read
  reg  [7:0] exp_q[$];          // Bytes due at the peer
  integer    num_errors = 0;
  integer    checks = 0;
  integer    i, n;
  // Pins carry the port while it drives, else the peer
  assign pins = peer_oe ? peer_q : peer_drv;
  sbph_port uut
  (
    .CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .ADR_I(adr), .HOST_D_I(hd), .HOST_D_O(host_q),
    .HOST_D_OE_O(host_oe), .PEER_D_I(pins), .PEER_D_O(peer_q),
    .PEER_D_OE_O(peer_oe), .PEER_STROBE_N_I(stb_n),
    .PEER_ACK_N_I(ack_n), .OUT_LATCH_FULL_N_O(obf_n),
    .IN_LATCH_FULL_O(in_latch_full), .IRQ_OUT_O(irq), .THIRD_LOW_I(low_in),
    .GROUP_B_MODE_I(gb_mode), .GROUP_B_DIR_IN_I(1'b0),
    .GROUP_B_FULL_I(gb_full), .GROUP_B_IRQ_I(gb_irq),
    .THIRD_LOW_O(low_q), .THIRD_LOW_OE_O(low_oe),
    .LOW_DIR_IN_I(low_dir), .GROUP_B_IRQ_EN_O(gb_en)
  );
  sbph_peer_model u_peer
  (
    .clk_i(clk), .pins_i(pins), .obf_n_i(obf_n), .pins_o(peer_drv),
    .strobe_n_o(stb_n), .ack_n_o(ack_n)
  );
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Next xorshift value
  function [31:0] xs(input [31:0] s);
  begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  end
  endfunction
  // Expected status word from flag bits and group B inputs
  function [7:0] stat(input [4:0] hi);
    stat = {hi, gb_mode ? {1'b1, gb_full, gb_irq} : low_in};
  endfunction
  // Compare and count
  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // One host cycle; strobes held well past synchronisation
  task host(input w, input [1:0] a, input [7:0] d);
  begin
    @(posedge clk);
    cs_n <= 1'b0;
    adr <= a;
    hd <= d;
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (8) @(posedge clk);
    q = host_q;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    // Select, address and data stand until the synced strobe rises
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  end
  endtask
  // Report counts and end the run
  task print_verdict;
  begin
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // Cut a hang short, far beyond the expected run
  initial
  begin
    #400000;
    num_errors++;
    print_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("obf_n", 1, obf_n);
    chk("ibf", 0, in_latch_full);
    chk("irq", 0, irq);
    host(0, 2'b10, 0);
    chk("status", stat(5'h10), q);
    host(1, 2'b11, 8'h09);
    host(1, 2'b11, 8'h0d);
    // Receive bytes; last one with receive enable off
    for (n = 0; n < 4; n++)
    begin
      seed = xs(seed);
      low_in <= seed[10:8];
      if (n == 3) host(1, 2'b11, 8'h08);
      u_peer.send(seed[7:0]);
      chk("ibf", 1, in_latch_full);
      chk("irq", n < 3, irq);
      host(0, 2'b10, 0);
      chk("status", stat({3'b111, n < 3, n < 3}), q);
      host(0, 2'b00, 0);
      chk("rx byte", seed[7:0], q);
      chk("ibf", 0, in_latch_full);
      chk("irq", 0, irq);
    end
    // Send four bytes while the peer stalls, then drain
    for (n = 0; n < 3; n++)
    begin
      u_peer.stall = 1'b1;
      if (n == 2) host(1, 2'b11, 8'h0c);
      for (i = 0; i < 4; i++)
      begin
        seed = xs(seed);
        exp_q.push_back(seed[7:0]);
        host(1, 2'b00, seed[7:0]);
      end
      chk("obf_n", 0, obf_n);
      chk("peer_oe", 0, peer_oe);
      chk("irq", 0, irq);
      host(0, 2'b10, 0);
      chk("status", stat({1'b0, n < 2, 3'b000}), q);
      u_peer.gap = n * 7;
      u_peer.stall = 1'b0;
      for (i = 0; i < 600 && u_peer.got_q.size() < 4; i++) @(posedge clk);
      repeat (12) @(posedge clk);
      chk("obf_n", 1, obf_n);
      chk("irq", n < 2, irq);
      chk("tx count", 4, u_peer.got_q.size());
      while (u_peer.got_q.size() > 0 && exp_q.size() > 0)
        chk("tx byte", exp_q.pop_front(), u_peer.got_q.pop_front());
      exp_q.delete();
    end
    // Plain writes reach three low bits only
    host(1, 2'b10, 8'hff);
    chk("low out", 8'h07, low_q);
    host(0, 2'b10, 0);
    chk("status", stat(5'h10), q);
    host(1, 2'b11, 8'h02);
    chk("low out", 8'h05, low_q);
    // Group B strobed: low status bits follow its flags
    gb_mode <= 1'b1;
    host(1, 2'b11, 8'h05);
    chk("gb_en", 1, gb_en);
    for (n = 0; n < 4; n++)
    begin
      gb_full <= n[0];
      gb_irq <= n[1];
      host(0, 2'b10, 0);
      chk("status", stat(5'h10), q);
    end
    print_verdict;
  end
endmodule // testbench
